// ==== align_ctrl_pkg.sv ====
/*
 * Shared constants and carriers for the receive alignment control block:
 * register indices, field positions, reset values and status codes.
 * Assumes a 32-bit Avalon-MM bus; each register index is a word index.
 */
`default_nettype none
package align_ctrl_pkg;
  localparam int NUM_BLK = 2;
  localparam int NUM_CH = 4;
  localparam int IDX_W = 18;
  // Register word indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_MEMBER_A = 18'h30810;
  localparam logic [IDX_W-1:0] IDX_MEMBER_B = 18'h30910;
  localparam logic [IDX_W-1:0] IDX_CTRL_A = 18'h30820;
  localparam logic [IDX_W-1:0] IDX_CTRL_B = 18'h30920;
  localparam logic [IDX_W-1:0] IDX_BYPASS_A = 18'h30821;
  localparam logic [IDX_W-1:0] IDX_BYPASS_B = 18'h30921;
  localparam logic [IDX_W-1:0] IDX_STATUS_A = 18'h30804;
  localparam logic [IDX_W-1:0] IDX_STATUS_B = 18'h30904;
  localparam logic [IDX_W-1:0] IDX_LSEL_A = 18'h30830;
  localparam logic [IDX_W-1:0] IDX_LSEL_B = 18'h30930;
  localparam logic [IDX_W-1:0] IDX_SPARE_B = 18'h30933;
  // Field positions within the low byte.
  localparam int BIT_FIRST_RESYNC = 2;
  localparam int BIT_SECOND_RESYNC = 3;
  localparam int BIT_PAIR_RESYNC = 5;
  localparam int BIT_TEN_GIG = 7;
  localparam int BIT_BYPASS = 0;
  localparam int BIT_MEMBER_FIRST = 6;
  localparam int BIT_MEMBER_SECOND = 7;
  localparam int BIT_LSEL_FIRST = 0;
  localparam int BIT_LSEL_SECOND = 1;
  localparam int POS_FIRST_STATE = 4;
  localparam int POS_SECOND_STATE = 6;
  // Link state codes.
  localparam logic [1:0] LS_NO_SYNC = 2'h0;
  localparam logic [1:0] LS_SYNC_DONE = 2'h2;
  localparam logic [1:0] LS_NO_COMMA_CV = 2'h1;
  localparam logic [1:0] LS_UNUSED = 2'h3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic ten_gig;
    logic pair_resync;
    logic second_resync;
    logic first_resync;
  } ctrl_s;
endpackage : align_ctrl_pkg
`default_nettype wire

// ==== serdes_align_resync_ctrl.sv ====
/*
 * Receive alignment control and link state status for a two-block,
 * four-channel transceiver, reached over an Avalon-MM slave.
 * Assumes link state inputs and the bus are synchronous to CLOCK.
 */
// Decided for this implementation: the Avalon-MM register port.
// Overview of operation
// - Single-channel resync bit rise resets channel pointers
// - Pair resync bit rise resyncs block group
// - Ten-gig mode forces both channels' link machine
// - Ten-gig mode bit resets to zero
// - Bypass bit routes data around alignment FIFOs
// - Status registers read-only, cleared on read
// - Status codes: 00, 10 done, 01 violation
// - Status fields at bits 4-5 and 6-7
// - Only member channels join group alignment
`timescale 1ns/1ps
`default_nettype none
module serdes_align_resync_ctrl (
  // Clock, reset and enable
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic CE,
  // Avalon-MM slave
  input wire logic [19:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // Link state machine condition, two bits per channel
  input wire logic [7:0] LINK_STATE,
  // Alignment path controls, one bit per channel or block
  output logic [3:0] PTR_RESYNC,
  output logic [1:0] PAIR_RESYNC,
  output logic [3:0] TEN_GIG_SEL,
  output logic [3:0] GROUP_MEMBER,
  output logic [1:0] ALIGN_BYPASS
);

  ////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [align_ctrl_pkg::IDX_W-1:0] idx;
  logic hit_aligned;
  logic req;
  logic take;
  logic wr_take;
  logic wr_lane;
  logic [7:0] wbyte;

  assign idx = ADDRESS[19:2];
  assign hit_aligned = (ADDRESS[1:0] == 2'h0);
  assign req = READ | WRITE;
  // A request is answered on the edge where waitrequest is seen low.
  assign take = CE & req & ~WAITREQUEST;
  assign wr_lane = WRITE & BYTEENABLE[0] & hit_aligned;
  assign wr_take = take & wr_lane;
  assign wbyte = WRITEDATA[7:0];

  ////////////////////////////////////////////////////////////////////
  // Register state

  align_ctrl_pkg::ctrl_s ctrl [align_ctrl_pkg::NUM_BLK];
  logic [1:0] bypass;
  logic [3:0] member;
  logic [3:0] lsel;
  logic [7:0] status [align_ctrl_pkg::NUM_BLK];
  logic [3:0] chan_prev;
  logic [1:0] pair_prev;
  logic [3:0] chan_bits;
  logic [1:0] pair_bits;
  logic [1:0] ten_bits;
  logic [1:0] rd_status;

  genvar b;
  generate
    for (b = 0; b < align_ctrl_pkg::NUM_BLK; b++) begin : g_blk
      localparam logic [align_ctrl_pkg::IDX_W-1:0] I_CTRL =
        (b == 0) ? align_ctrl_pkg::IDX_CTRL_A : align_ctrl_pkg::IDX_CTRL_B;
      localparam logic [align_ctrl_pkg::IDX_W-1:0] I_BYP =
        (b == 0) ? align_ctrl_pkg::IDX_BYPASS_A : align_ctrl_pkg::IDX_BYPASS_B;
      localparam logic [align_ctrl_pkg::IDX_W-1:0] I_MEM =
        (b == 0) ? align_ctrl_pkg::IDX_MEMBER_A : align_ctrl_pkg::IDX_MEMBER_B;
      localparam logic [align_ctrl_pkg::IDX_W-1:0] I_LSEL =
        (b == 0) ? align_ctrl_pkg::IDX_LSEL_A : align_ctrl_pkg::IDX_LSEL_B;
      localparam logic [align_ctrl_pkg::IDX_W-1:0] I_STAT =
        (b == 0) ? align_ctrl_pkg::IDX_STATUS_A : align_ctrl_pkg::IDX_STATUS_B;
      logic [1:0] in_first;
      logic [1:0] in_second;
      logic [7:0] next_status;

      assign chan_bits[2*b] = ctrl[b].first_resync;
      assign chan_bits[2*b+1] = ctrl[b].second_resync;
      assign pair_bits[b] = ctrl[b].pair_resync;
      assign ten_bits[b] = ctrl[b].ten_gig;
      // Status register for this block is read in the same way as any word.
      assign rd_status[b] = CE & req & WAITREQUEST & READ & hit_aligned &
        (idx == I_STAT);
      assign in_first = LINK_STATE[4*b+1 -: 2];
      assign in_second = LINK_STATE[4*b+3 -: 2];

      // Control word; the mode bit resets low so Fibre Channel is default.
      always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
          ctrl[b] <= '0;
        end else if (CE && wr_take && idx == I_CTRL) begin
          ctrl[b].first_resync <= wbyte[align_ctrl_pkg::BIT_FIRST_RESYNC];
          ctrl[b].second_resync <= wbyte[align_ctrl_pkg::BIT_SECOND_RESYNC];
          ctrl[b].pair_resync <= wbyte[align_ctrl_pkg::BIT_PAIR_RESYNC];
          ctrl[b].ten_gig <= wbyte[align_ctrl_pkg::BIT_TEN_GIG];
        end
      end

      always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
          bypass[b] <= 1'b0;
          member[2*b+1 -: 2] <= 2'h0;
          lsel[2*b+1 -: 2] <= 2'h0;
        end else if (CE && wr_take) begin
          if (idx == I_BYP) begin
            bypass[b] <= wbyte[align_ctrl_pkg::BIT_BYPASS];
          end
          if (idx == I_MEM) begin
            member[2*b] <= wbyte[align_ctrl_pkg::BIT_MEMBER_FIRST];
            member[2*b+1] <= wbyte[align_ctrl_pkg::BIT_MEMBER_SECOND];
          end
          if (idx == I_LSEL) begin
            lsel[2*b] <= wbyte[align_ctrl_pkg::BIT_LSEL_FIRST];
            lsel[2*b+1] <= wbyte[align_ctrl_pkg::BIT_LSEL_SECOND];
          end
        end
      end

      // A reported condition replaces the held one; the unused code is
      // never stored. A new report in the read cycle wins over the clear.
      always_comb begin
        next_status = status[b];
        if (rd_status[b]) begin
          next_status = align_ctrl_pkg::RST_BYTE;
        end
        if (in_first == align_ctrl_pkg::LS_SYNC_DONE ||
            in_first == align_ctrl_pkg::LS_NO_COMMA_CV) begin
          next_status[align_ctrl_pkg::POS_FIRST_STATE +: 2] = in_first;
        end
        if (in_second == align_ctrl_pkg::LS_SYNC_DONE ||
            in_second == align_ctrl_pkg::LS_NO_COMMA_CV) begin
          next_status[align_ctrl_pkg::POS_SECOND_STATE +: 2] = in_second;
        end
      end

      always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
          status[b] <= align_ctrl_pkg::RST_BYTE;
        end else if (CE) begin
          status[b] <= next_status;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Resync edge detection and control outputs

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      chan_prev <= 4'h0;
      pair_prev <= 2'h0;
      PTR_RESYNC <= 4'h0;
      PAIR_RESYNC <= 2'h0;
    end else if (CE) begin
      chan_prev <= chan_bits;
      pair_prev <= pair_bits;
      PAIR_RESYNC <= pair_bits & ~pair_prev;
      // A group resync only reaches channels that belong to the group.
      PTR_RESYNC <= (chan_bits & ~chan_prev) |
        ({{2{pair_bits[1] & ~pair_prev[1]}}, {2{pair_bits[0] & ~pair_prev[0]}}}
          & member);
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      TEN_GIG_SEL <= 4'h0;
      GROUP_MEMBER <= 4'h0;
      ALIGN_BYPASS <= 2'h0;
    end else if (CE) begin
      // The block mode overrides the per-channel machine choice.
      TEN_GIG_SEL <= {{2{ten_bits[1]}}, {2{ten_bits[0]}}} | lsel;
      GROUP_MEMBER <= member;
      ALIGN_BYPASS <= bypass;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus answer: one wait cycle, read data registered with it

  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = align_ctrl_pkg::RD_ZERO;
    if (hit_aligned) begin
      unique case (idx)
        align_ctrl_pkg::IDX_CTRL_A: next_rdata[7:0] = {ctrl[0].ten_gig, 1'b0,
          ctrl[0].pair_resync, 1'b0, ctrl[0].second_resync,
          ctrl[0].first_resync, 2'h0};
        align_ctrl_pkg::IDX_CTRL_B: next_rdata[7:0] = {ctrl[1].ten_gig, 1'b0,
          ctrl[1].pair_resync, 1'b0, ctrl[1].second_resync,
          ctrl[1].first_resync, 2'h0};
        align_ctrl_pkg::IDX_BYPASS_A: next_rdata[0] = bypass[0];
        align_ctrl_pkg::IDX_BYPASS_B: next_rdata[0] = bypass[1];
        align_ctrl_pkg::IDX_MEMBER_A: next_rdata[7:6] = member[1:0];
        align_ctrl_pkg::IDX_MEMBER_B: next_rdata[7:6] = member[3:2];
        align_ctrl_pkg::IDX_LSEL_A: next_rdata[1:0] = lsel[1:0];
        align_ctrl_pkg::IDX_LSEL_B: next_rdata[1:0] = lsel[3:2];
        align_ctrl_pkg::IDX_STATUS_A: next_rdata[7:0] = status[0];
        align_ctrl_pkg::IDX_STATUS_B: next_rdata[7:0] = status[1];
        default: next_rdata = align_ctrl_pkg::RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      WAITREQUEST <= 1'b1;
      READDATA <= align_ctrl_pkg::RD_ZERO;
    end else if (CE) begin
      WAITREQUEST <= ~(req & WAITREQUEST);
      if (req && WAITREQUEST && READ) begin
        READDATA <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  a_chan_edge_pulse: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    CE && chan_bits[0] && !chan_prev[0] |=> PTR_RESYNC[0])
    else $error("channel resync edge gave no pointer reset");

  a_pulse_one_cycle: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    CE && PTR_RESYNC[1] |=> !PTR_RESYNC[1])
    else $error("pointer reset pulse held too long");

  a_pair_edge_pulse: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    CE && pair_bits[1] && !pair_prev[1] |=> PAIR_RESYNC[1]
      && (PTR_RESYNC[3:2] & $past(member[3:2])) == $past(member[3:2]))
    else $error("pair resync missed a member channel");

  a_member_gate: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    CE && pair_bits[0] && !pair_prev[0] && !member[0] && !chan_bits[0]
      |=> !PTR_RESYNC[0])
    else $error("non-member channel reset by pair resync");

  a_ten_gig_override: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    CE && ten_bits[0] |=> TEN_GIG_SEL[1:0] == 2'h3)
    else $error("ten-gig mode did not force link machine");

  a_bypass_follow: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    CE && wr_take && idx == align_ctrl_pkg::IDX_BYPASS_B ##1 CE
      |=> ALIGN_BYPASS[1] == $past(WRITEDATA[0], 2))
    else $error("bypass output does not follow write");

  a_status_clear: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    rd_status[0] && LINK_STATE[3:0] == 4'h0 |=> status[0] == 8'h00
      && !WAITREQUEST)
    else $error("status not cleared by read");

  a_status_code: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    status[1][5:4] != align_ctrl_pkg::LS_UNUSED
      && status[1][7:6] != align_ctrl_pkg::LS_UNUSED && status[1][3:0] == 4'h0)
    else $error("status holds unused code or reserved bit");

  a_status_field: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    CE && LINK_STATE[7:6] == align_ctrl_pkg::LS_SYNC_DONE
      |=> status[1][7:6] == align_ctrl_pkg::LS_SYNC_DONE)
    else $error("second channel state not captured");

  a_mode_default: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    !ten_bits[1] && !(CE && wr_take) |=> !ten_bits[1])
    else $error("ten-gig mode set without a write");

  a_wait_answer: assert property (
    @(posedge CLOCK) disable iff (!RST_B)
    CE && req && WAITREQUEST |=> !WAITREQUEST)
    else $error("request not answered after one wait cycle");

endmodule : serdes_align_resync_ctrl
`default_nettype wire

// ==== serdes_align_resync_ctrl_tb.sv ====
/*
 * Self-checking testbench for the receive alignment control block.
 * Assumes the block answers every Avalon-MM request within a few cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module serdes_align_resync_ctrl_tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [19:0] address = 20'h00000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [7:0] link_state = 8'h00;
  logic [31:0] readdata;
  logic waitrequest;
  logic [3:0] ptr_resync, ten_gig_sel, group_member;
  logic [1:0] pair_resync, align_bypass;
  logic [31:0] read_q[$];
  logic [5:0] pulse_q[$];
  int mismatches = 0;
  int tests_run = 0;
  int seed = 96705;
  logic [1:0] code [4];

  always #4 clock = ~clock;

  serdes_align_resync_ctrl u_dut (.CLOCK(clock), .RST_B(rst_b), .CE(ce), .ADDRESS(address),
    .READ(read), .WRITE(write), .BYTEENABLE(byteenable), .WRITEDATA(writedata),
    .READDATA(readdata), .WAITREQUEST(waitrequest), .LINK_STATE(link_state),
    .PTR_RESYNC(ptr_resync), .PAIR_RESYNC(pair_resync), .TEN_GIG_SEL(ten_gig_sel),
    .GROUP_MEMBER(group_member), .ALIGN_BYPASS(align_bypass));

  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  task automatic note(input logic ok, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : note

  task automatic cmp_read(input logic [31:0] got, input logic [31:0] exp);
    note(got === exp, got, exp);
  endtask : cmp_read

  task automatic cmp_pulse(input logic [5:0] got, input logic [5:0] exp);
    note(got === exp, 32'(got), 32'(exp));
  endtask : cmp_pulse

  task automatic cmp_level(input logic [3:0] got, input logic [3:0] exp);
    note(got === exp, 32'(got), 32'(exp));
  endtask : cmp_level

  // One transfer; the request stands until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [17:0] idx, input logic [1:0] lo,
                     input logic [3:0] be, input logic [7:0] wd);
    int n;
    @(posedge clock);
    address <= {idx, lo};
    read <= !wr;
    write <= wr;
    byteenable <= be;
    writedata <= {24'($random(seed)), wd};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      mismatches++;
      final_report();
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr_reg(input logic [17:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, 2'b00, 4'hf, wd);
  endtask : wr_reg

  task automatic rd_reg(input logic [17:0] idx, input logic [7:0] exp);
    read_q.push_back({24'h000000, exp});
    bus(1'b0, idx, 2'b00, 4'hf, 8'h00);
  endtask : rd_reg

  // Levels lag their register by one cycle after the write edge.
  task automatic settle;
    repeat (2) @(posedge clock);
  endtask : settle

  //////////////////////////////////////////////////////////////////////////////
  // Monitor: read answers and resync pulses are matched against the notes.
  always @(posedge clock) begin
    if (rst_b && read && waitrequest === 1'b0) begin
      if (read_q.size() == 0) note(1'b0, readdata, 32'h0000_0000);
      else cmp_read(readdata, read_q.pop_front());
    end
    if (rst_b && {pair_resync, ptr_resync} !== 6'h00) begin
      if (pulse_q.size() == 0) note(1'b0, 32'({pair_resync, ptr_resync}), 32'h0000_0000);
      else cmp_pulse({pair_resync, ptr_resync}, pulse_q.pop_front());
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    foreach (code[i]) code[i] = 2'h0;
    rd_reg(align_ctrl_pkg::IDX_STATUS_A, 8'h00);
    rd_reg(align_ctrl_pkg::IDX_STATUS_B, 8'h00);
    rd_reg(align_ctrl_pkg::IDX_CTRL_A, 8'h00);
    rd_reg(align_ctrl_pkg::IDX_CTRL_B, 8'h00);
    rd_reg(align_ctrl_pkg::IDX_BYPASS_A, 8'h00);
    rd_reg(align_ctrl_pkg::IDX_MEMBER_B, 8'h00);
    rd_reg(align_ctrl_pkg::IDX_SPARE_B, 8'h00);
    rd_reg(18'h30822, 8'h00);
    read_q.push_back(32'h0000_0000);
    bus(1'b0, align_ctrl_pkg::IDX_CTRL_A, 2'b01, 4'hf, 8'h00);
    cmp_level(ten_gig_sel, 4'h0);
    cmp_level({2'b00, align_bypass}, 4'h0);
    cmp_level(group_member, 4'h0);
    // Both single resyncs and the pair resync rise together; no member channels yet.
    pulse_q.push_back(6'b01_0011);
    wr_reg(align_ctrl_pkg::IDX_CTRL_A, 8'hff);
    rd_reg(align_ctrl_pkg::IDX_CTRL_A, 8'hac);
    cmp_level(ten_gig_sel, 4'h3);
    wr_reg(align_ctrl_pkg::IDX_CTRL_A, 8'hff);
    wr_reg(align_ctrl_pkg::IDX_CTRL_A, 8'h00);
    wr_reg(align_ctrl_pkg::IDX_MEMBER_A, 8'h40);
    settle();
    cmp_level(ten_gig_sel, 4'h0);
    cmp_level(group_member, 4'h1);
    pulse_q.push_back(6'b01_0001);
    wr_reg(align_ctrl_pkg::IDX_CTRL_A, 8'h20);
    wr_reg(align_ctrl_pkg::IDX_LSEL_B, 8'h02);
    settle();
    cmp_level(ten_gig_sel, 4'h8);
    wr_reg(align_ctrl_pkg::IDX_CTRL_B, 8'h80);
    settle();
    cmp_level(ten_gig_sel, 4'hc);
    pulse_q.push_back(6'b00_1000);
    wr_reg(align_ctrl_pkg::IDX_CTRL_B, 8'h08);
    bus(1'b1, align_ctrl_pkg::IDX_CTRL_B, 2'b00, 4'he, 8'h04);
    rd_reg(align_ctrl_pkg::IDX_CTRL_B, 8'h08);
    settle();
    cmp_level(ten_gig_sel, 4'h8);
    // Pair resyncs of both blocks with only the second channel of each a member.
    wr_reg(align_ctrl_pkg::IDX_MEMBER_A, 8'h80);
    wr_reg(align_ctrl_pkg::IDX_CTRL_A, 8'h00);
    pulse_q.push_back(6'b01_0010);
    wr_reg(align_ctrl_pkg::IDX_CTRL_A, 8'h20);
    wr_reg(align_ctrl_pkg::IDX_MEMBER_B, 8'h80);
    pulse_q.push_back(6'b10_1000);
    wr_reg(align_ctrl_pkg::IDX_CTRL_B, 8'h20);
    pulse_q.push_back(6'b00_0100);
    wr_reg(align_ctrl_pkg::IDX_CTRL_B, 8'h24);
    cmp_level(group_member, 4'ha);
    wr_reg(align_ctrl_pkg::IDX_BYPASS_B, 8'hff);
    rd_reg(align_ctrl_pkg::IDX_BYPASS_B, 8'h01);
    settle();
    cmp_level({2'b00, align_bypass}, 4'h2);
    // Status fields latch 10 or 01 and hold through 00 and 11 until read.
    for (int k = 0; k < 4; k++) begin
      foreach (code[i]) begin
        code[i] = ($random(seed) & 1) ? align_ctrl_pkg::LS_SYNC_DONE
                                       : align_ctrl_pkg::LS_NO_COMMA_CV;
      end
      @(posedge clock);
      link_state <= {code[3], code[2], code[1], code[0]};
      repeat (2) @(posedge clock);
      link_state <= (k % 2 == 1) ? 8'hff : 8'h00;
      repeat (2) @(posedge clock);
      rd_reg(align_ctrl_pkg::IDX_STATUS_A, {code[1], code[0], 4'h0});
      rd_reg(align_ctrl_pkg::IDX_STATUS_B, {code[3], code[2], 4'h0});
      rd_reg(align_ctrl_pkg::IDX_STATUS_A, 8'h00);
      wr_reg(align_ctrl_pkg::IDX_STATUS_B, 8'hff);
      rd_reg(align_ctrl_pkg::IDX_STATUS_B, 8'h00);
    end
    repeat (10) @(posedge clock);
    note(pulse_q.size() == 0 && read_q.size() == 0, 32'(pulse_q.size()), 32'h0000_0000);
    final_report();
  end
endmodule : serdes_align_resync_ctrl_tb
`default_nettype wire
